// ### core/aes_defs.svh
// register map, field positions, reset values and frame counts of the side data core
`ifndef AES_DEFS_SVH
`define AES_DEFS_SVH

// register byte offsets on the bus
`define AES_CTRL_OFS    8'h00
`define AES_STAT_OFS    8'h04
`define AES_CSBUF_LO    8'h40
`define AES_CSBUF_HI    8'h6C

// control register fields
`define AES_CTRL_DIR    0
`define AES_CTRL_FLAW   1
`define AES_CTRL_BYPASS 3
`define AES_CTRL_MONO   4
`define AES_CTRL_OFF    7
`define AES_CTRL_PHASE  8
`define AES_CTRL_SRST   9
`define AES_CTRL_PDN    10
`define AES_CTRL_W      11
`define AES_CTRL_RST    11'h400

// status register fields
`define AES_STAT_FRAME_HI 8
`define AES_STAT_ARMED    9
`define AES_STAT_RUN      10
`define AES_STAT_BS       11
`define AES_STAT_HW       12
`define AES_STAT_PER_LO   16

// synchronised pin vector positions
`define AES_PIN_STROBE  0
`define AES_PIN_BSIN    1
`define AES_PIN_USER    2
`define AES_PIN_FLAW    3
`define AES_PIN_CSER    4
`define AES_PIN_EXT     5
`define AES_PIN_HW      6
`define AES_PIN_DIR     7
`define AES_PIN_FMT0    8
`define AES_PIN_FMT1    9
`define AES_PIN_METHOD  10
`define AES_PIN_COPY    11
`define AES_PIN_GEN     12
`define AES_PIN_NPCM_N  13
`define AES_PIN_FILT_N  14
`define AES_PIN_W       15

// frame and block counts
`define AES_LAST_STEREO 9'h0BF
`define AES_LAST_MONO   9'h17F
`define AES_CS_LEN      9'h0C0
`define AES_CS_RIGHT    4'h6
`define AES_HALF_LAST   7'h7F
`define AES_FMT_I2S     2'h1

// preamble half-cell patterns for a preceding low level
`define AES_PRE_X       8'hE2
`define AES_PRE_Y       8'hE4
`define AES_PRE_Z       8'hE8

`endif

// ### core/aes_pkg.sv
// types shared by the side data core
package aes_pkg;

	typedef logic [31:0] aes_word_t;

	// source feeding the line driver
	typedef enum logic [1:0] {
		SRC_MUTE = 2'b00,
		SRC_ENC  = 2'b01,
		SRC_EXT  = 2'b10
	} aes_src_e;

endpackage : aes_pkg

// ### core/aes_cs_ram.sv
// channel status buffer memory with one write port and two registered read ports
`timescale 1ns/1ps
`default_nettype none

module aes_cs_ram #(
	parameter int DEPTH = 12,
	parameter int AW    = 4,
	parameter int DW    = 32
) (
	input  wire logic          clock,   // core clock
	input  wire logic          rst,     // async reset, active high
	input  wire logic          we,      // write strobe
	input  wire logic [AW-1:0] waddr,   // write word address
	input  wire logic [DW-1:0] wdata,   // write data
	input  wire logic [AW-1:0] ra_addr, // encoder read address
	output var  logic [DW-1:0] ra_data, // encoder read data, registered
	input  wire logic [AW-1:0] rb_addr, // bus read address
	output var  logic [DW-1:0] rb_data  // bus read data, registered
);

	logic [DW-1:0] mem [DEPTH];

	// write port
	always_ff @(posedge clock) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end

	// registered read ports, out of range reads give zero
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			ra_data <= '0;
			rb_data <= '0;
		end else begin
			ra_data <= (int'(ra_addr) < DEPTH) ? mem[ra_addr] : '0;
			rb_data <= (int'(rb_addr) < DEPTH) ? mem[rb_addr] : '0;
		end
	end

endmodule : aes_cs_ram

`default_nettype wire

// ### core/aes_side_core.sv
// side data multiplexer, block start, bi-phase mark coder and line driver source
`timescale 1ns/1ps
`default_nettype none
`include "aes_defs.svh"
// Overview of operation
// RULE1: audio, status, user and validity bits merged into one bi-phase coded stream
// RULE2: block start marks frame 0, the first frame of a status block
// RULE3: block start direction follows select, 0 input 1 output, register or pin
// RULE4: input block start sampled on rising strobe if phase 0, falling if 1
// RULE5: source drives block start high at the sample instant to start a block
// RULE6: output rises every 192nd falling strobe edge, 384th in mono, falls next
// RULE7: with phase 1 the output block start moves on rising strobe edges
// RULE8: hardware mode uses phase 0 for justified formats, phase 1 for I2S
// RULE9: software mode takes status bits from a host loaded buffer
// RULE10: hardware mode method 0 builds status from four static pins
// RULE11: copy and generation pins pick consumer bits or studio mode
// RULE12: non-PCM pin 0 means linear audio, 1 means encoded data
// RULE13: filter curve pin 0 means emphasis applied, 1 means none
// RULE14: hardware mode method 1 takes status serially on both strobe edges
// RULE15: user bits always enter serially on the user input
// RULE16: validity from a control bit in software mode, serial pin in hardware
// RULE17: validity 0 marks a usable sample, 1 a flawed one
// RULE18: software mode line source is encoder or external stream by bypass bit
// RULE19: hardware mode line source is always the encoder
// RULE20: both line outputs ground during resets and power-down
// RULE21: output disable bit forces both line outputs to ground
// RULE22: after reset outputs stay low until the first rising strobe edge
// RULE23: one strobe period carries exactly one transmitted frame
// RULE24: coder toggles at each cell edge, mid-cell for ones, preambles excepted

module aes_side_core (
	input  wire logic        CLOCK,                   // core clock, 250 MHz
	input  wire logic        RST,                     // async reset, active high
	input  wire logic        HSEL,                    // bus slave select
	input  wire logic [31:0] HADDR,                   // bus address
	input  wire logic [1:0]  HTRANS,                  // bus transfer type
	input  wire logic        HWRITE,                  // bus write
	input  wire logic [2:0]  HSIZE,                   // bus size, words only
	input  wire logic [31:0] HWDATA,                  // bus write data
	input  wire logic        HREADY,                  // bus ready in
	output var  logic [31:0] HRDATA,                  // bus read data
	output var  logic        HREADYOUT,               // bus ready out
	output var  logic        HRESP,                   // bus response, always okay
	input  wire logic [23:0] AUDIO_LEFT,              // left sample from the audio port
	input  wire logic [23:0] AUDIO_RIGHT,             // right sample from the audio port
	input  wire logic        FRAME_STROBE,            // frame rate strobe pin
	input  wire logic        HW_MODE,                 // hardware mode strap
	input  wire logic        BLOCK_START_DIR_SELECT,  // hardware direction pin
	input  wire logic [1:0]  FORMAT_SEL,              // hardware audio format pins
	input  wire logic        STATUS_INPUT_METHOD_SELECT, // hardware status method pin
	input  wire logic        COPY_PIN,                // consumer copy pin
	input  wire logic        GENERATION_PIN,          // consumer generation pin
	input  wire logic        NON_PCM_N,               // data type pin
	input  wire logic        FILTER_CURVE_FLAG_N,     // emphasis pin
	input  wire logic        STATUS_SERIAL,           // serial status pin
	input  wire logic        USER_SERIAL,             // serial user pin
	input  wire logic        SAMPLE_FLAWED_SERIAL,    // serial validity pin
	input  wire logic        EXTERNAL_BIPHASE_IN,     // external coded stream
	input  wire logic        BLOCK_START_LINE_IN,     // block start pin, input side
	output var  logic        BLOCK_START_LINE_OUT,    // block start pin, output side
	output var  logic        BLOCK_START_LINE_OE,     // block start pin drive enable
	output var  logic        LINE_OUT_P,              // line driver, true side
	output var  logic        LINE_OUT_N               // line driver, inverted side
);

	typedef struct packed {
		logic [`AES_PIN_W-1:0]  p1;
		logic [`AES_PIN_W-1:0]  p2;
		logic [`AES_PIN_W-1:0]  p3;
		logic [`AES_PIN_W-1:0]  pin;
		logic [`AES_PIN_W-1:0]  pin_q;
		logic [2:0]             warm;
		logic [`AES_CTRL_W-1:0] ctrl;
		logic                   ap_valid;
		logic                   ap_write;
		logic [7:0]             ap_addr;
		logic [31:0]            hrdata;
		logic                   hreadyout;
		logic                   hresp;
		logic [15:0]            pcnt;
		logic [15:0]            period;
		logic [8:0]             half_len;
		logic [8:0]             hcnt;
		logic [6:0]             half;
		logic                   running;
		logic                   level;
		logic                   start_level;
		logic [8:0]             frame;
		logic                   armed;
		logic [23:0]            aud_l;
		logic [23:0]            aud_r;
		logic                   u_a;
		logic                   u_b;
		logic                   v_a;
		logic                   v_b;
		logic                   c_a;
		logic                   c_b;
		logic                   bs_out;
		logic                   bs_oe;
		logic                   line_p;
		logic                   line_n;
	} aes_core_s;

	aes_core_s r;
	aes_core_s next_r;

	logic [`AES_PIN_W-1:0] pins;
	logic                  hw_mode;
	logic                  dir_eff;
	logic                  phase_eff;
	logic                  mono;
	logic                  st_rise;
	logic                  st_fall;
	logic                  frame_edge;
	logic                  bs_edge;
	logic                  bs_hit;
	logic                  soft_hold;
	logic                  muted;
	logic                  accept;
	logic                  sub;
	logic [8:0]            frame_last;
	logic [8:0]            cs_full;
	logic [7:0]            cs_idx;
	logic [3:0]            mem_ra;
	logic [31:0]           mem_rd_a;
	logic [31:0]           mem_rd_b;
	logic                  mem_we;
	logic                  cbit;
	logic                  vbit;
	logic                  ubit;
	logic [26:0]           body;
	aes_pkg::aes_word_t    word;
	aes_pkg::aes_src_e     src_sel;

	// true when a byte offset falls inside the status buffer
	function automatic logic is_csbuf(input logic [7:0] a);
		is_csbuf = (a >= `AES_CSBUF_LO) && (a <= `AES_CSBUF_HI) && (a[1:0] == 2'h0);
	endfunction : is_csbuf

	// buffer word index of a byte offset
	function automatic logic [3:0] buf_index(input logic [7:0] a);
		logic [7:0] d;
		d = a - `AES_CSBUF_LO;
		buf_index = d[5:2];
	endfunction : buf_index

	// status bit built from the static pins for a given block position
	function automatic logic cs_static(input logic [7:0] idx, input logic cp, input logic gn,
		input logic npcm_n, input logic filt_n);
		logic studio_use_flag;
		studio_use_flag = cp & gn;
		case (idx)
			8'h00: cs_static = studio_use_flag;
			8'h01: cs_static = npcm_n;
			8'h02: cs_static = studio_use_flag | cp;
			8'h03: cs_static = ~filt_n;
			8'h0F: cs_static = ~studio_use_flag & gn;
			default: cs_static = 1'h0;
		endcase
	endfunction : cs_static

	// raw pins gathered for the synchroniser
	assign pins = {FILTER_CURVE_FLAG_N, NON_PCM_N, GENERATION_PIN, COPY_PIN,
		STATUS_INPUT_METHOD_SELECT, FORMAT_SEL, BLOCK_START_DIR_SELECT, HW_MODE,
		EXTERNAL_BIPHASE_IN, STATUS_SERIAL, SAMPLE_FLAWED_SERIAL, USER_SERIAL,
		BLOCK_START_LINE_IN, FRAME_STROBE};

	// mode selection and strobe edges
	assign hw_mode    = r.pin[`AES_PIN_HW];
	assign dir_eff    = hw_mode ? r.pin[`AES_PIN_DIR] : r.ctrl[`AES_CTRL_DIR]; // RULE3
	assign phase_eff  = hw_mode ? (r.pin[`AES_PIN_FMT1:`AES_PIN_FMT0] == `AES_FMT_I2S)
		: r.ctrl[`AES_CTRL_PHASE]; // RULE8
	assign mono       = ~hw_mode & r.ctrl[`AES_CTRL_MONO];
	assign st_rise    = (r.warm == 3'h7) & r.pin[`AES_PIN_STROBE] & ~r.pin_q[`AES_PIN_STROBE];
	assign st_fall    = (r.warm == 3'h7) & ~r.pin[`AES_PIN_STROBE] & r.pin_q[`AES_PIN_STROBE];
	assign frame_edge = phase_eff ? st_fall : st_rise; // RULE4 RULE23
	assign bs_edge    = phase_eff ? st_rise : st_fall; // RULE6 RULE7
	assign bs_hit     = ~dir_eff & frame_edge & r.pin[`AES_PIN_BSIN]; // RULE5
	assign soft_hold  = ~hw_mode & (r.ctrl[`AES_CTRL_PDN] | r.ctrl[`AES_CTRL_SRST]);
	assign muted      = ~r.armed | soft_hold | (~hw_mode & r.ctrl[`AES_CTRL_OFF]);
	assign accept     = HSEL & HTRANS[1] & HREADY;

	// block position and status buffer addressing
	assign frame_last = mono ? `AES_LAST_MONO : `AES_LAST_STEREO;
	assign cs_full    = (r.frame >= `AES_CS_LEN) ? (r.frame - `AES_CS_LEN) : r.frame;
	assign cs_idx     = cs_full[7:0];
	assign sub        = r.half[6];
	assign mem_ra     = (sub ? `AES_CS_RIGHT : 4'h0) + {1'h0, cs_idx[7:5]};
	assign mem_we     = r.ap_valid & r.ap_write & is_csbuf(r.ap_addr);

	// side bits for the subframe now on the line
	assign ubit = sub ? r.u_b : r.u_a; // RULE15
	assign vbit = hw_mode ? (sub ? r.v_b : r.v_a) : r.ctrl[`AES_CTRL_FLAW]; // RULE16 RULE17
	assign cbit = ~hw_mode ? mem_rd_a[cs_idx[4:0]] // RULE9
		: r.pin[`AES_PIN_METHOD] ? (sub ? r.c_b : r.c_a) // RULE14
		: cs_static(cs_idx, r.pin[`AES_PIN_COPY], r.pin[`AES_PIN_GEN],
			r.pin[`AES_PIN_NPCM_N], r.pin[`AES_PIN_FILT_N]); // RULE10 RULE11 RULE12 RULE13
	assign body = {cbit, ubit, vbit, (sub & ~mono) ? r.aud_r : r.aud_l}; // RULE1
	assign word = {^body, body, 4'h0};

	// line driver source
	always_comb begin
		if (muted) begin
			src_sel = aes_pkg::SRC_MUTE; // RULE20 RULE21 RULE22
		end else if (~hw_mode & r.ctrl[`AES_CTRL_BYPASS]) begin
			src_sel = aes_pkg::SRC_EXT; // RULE18
		end else begin
			src_sel = aes_pkg::SRC_ENC; // RULE19
		end
	end

	aes_cs_ram #(
		.DEPTH (12),
		.AW    (4),
		.DW    (32)
	) u_cs_ram (
		.clock   (CLOCK),
		.rst     (RST),
		.we      (mem_we),
		.waddr   (buf_index(r.ap_addr)),
		.wdata   (HWDATA),
		.ra_addr (mem_ra),
		.ra_data (mem_rd_a),
		.rb_addr (buf_index(HADDR[7:0])),
		.rb_data (mem_rd_b)
	);

	// next state of the whole core
	always_comb begin
		logic       step;
		logic       zero;
		logic [7:0] pre;
		logic [5:0] h;
		step = 1'h0;
		zero = 1'h0;
		pre  = 8'h00;
		h    = 6'h00;
		next_r = r;
		// three stage pin synchroniser, change taken when stages two and three agree
		next_r.p1 = pins;
		next_r.p2 = r.p1;
		next_r.p3 = r.p2;
		for (int i = 0; i < `AES_PIN_W; i++) begin
			if (r.p2[i] == r.p3[i]) begin
				next_r.pin[i] = r.p3[i];
			end
		end
		next_r.pin_q = r.pin;
		// no strobe edge until the pin stages hold real levels, so a high strobe cannot arm
		if (r.warm != 3'h7) begin
			next_r.warm = r.warm + 3'h1;
		end
		// bus slave: writes without wait, reads with one wait state
		next_r.ap_valid = accept;
		if (accept) begin
			next_r.ap_write = HWRITE;
			next_r.ap_addr  = HADDR[7:0];
			if (~HWRITE) begin
				next_r.hreadyout = 1'h0;
			end
		end
		if (r.ap_valid & r.ap_write & (r.ap_addr == `AES_CTRL_OFS)) begin
			next_r.ctrl = HWDATA[`AES_CTRL_W-1:0];
		end
		if (r.ap_valid & ~r.ap_write) begin
			next_r.hreadyout = 1'h1;
			next_r.hrdata    = 32'h0;
			if (r.ap_addr == `AES_CTRL_OFS) begin
				next_r.hrdata[`AES_CTRL_W-1:0] = r.ctrl;
			end else if (r.ap_addr == `AES_STAT_OFS) begin
				next_r.hrdata[`AES_STAT_FRAME_HI:0] = r.frame;
				next_r.hrdata[`AES_STAT_ARMED] = r.armed;
				next_r.hrdata[`AES_STAT_RUN]   = r.running;
				next_r.hrdata[`AES_STAT_BS]    = r.bs_out;
				next_r.hrdata[`AES_STAT_HW]    = hw_mode;
				next_r.hrdata[31:`AES_STAT_PER_LO] = r.period;
			end else if (is_csbuf(r.ap_addr)) begin
				next_r.hrdata = mem_rd_b; // RULE9
			end
		end
		// strobe period measurement
		if (r.pcnt != 16'hFFFF) begin
			next_r.pcnt = r.pcnt + 16'h1;
		end
		// first rising strobe edge after any reset opens the line
		if (soft_hold) begin
			next_r.armed = 1'h0;
		end else if (st_rise) begin
			next_r.armed = 1'h1; // RULE22
		end
		// frame start: one strobe period is one frame of 128 half cells
		if (frame_edge) begin
			next_r.pcnt     = 16'h0;
			next_r.period   = r.pcnt;
			next_r.half_len = (r.pcnt[15:7] == 9'h0) ? 9'h1 : r.pcnt[15:7]; // RULE23
			next_r.hcnt     = 9'h0;
			next_r.half     = 7'h0;
			next_r.running  = r.armed;
			next_r.aud_l    = AUDIO_LEFT;
			next_r.aud_r    = AUDIO_RIGHT;
			if (bs_hit || r.frame >= frame_last) begin
				next_r.frame = 9'h0; // RULE2 RULE4
			end else begin
				next_r.frame = r.frame + 9'h1;
			end
			step = r.armed;
		end else if (r.running) begin
			if (r.hcnt >= r.half_len - 9'h1) begin
				next_r.hcnt = 9'h0;
				if (r.half == `AES_HALF_LAST) begin
					next_r.running = 1'h0;
				end else begin
					next_r.half = r.half + 7'h1;
					step = 1'h1;
				end
			end else begin
				next_r.hcnt = r.hcnt + 9'h1;
			end
		end
		if (soft_hold) begin
			next_r.frame   = 9'h0;
			next_r.running = 1'h0;
			step = 1'h0;
		end
		// bi-phase mark coder, one step per half cell
		zero = (next_r.frame == 9'h0) | (next_r.frame == `AES_CS_LEN);
		pre  = next_r.half[6] ? `AES_PRE_Y : (zero ? `AES_PRE_Z : `AES_PRE_X);
		h    = next_r.half[5:0];
		if (step) begin
			if (h == 6'h0) begin
				next_r.start_level = r.level;
				next_r.level = pre[7] ^ r.level; // RULE24
			end else if (h < 6'h8) begin
				next_r.level = pre[3'h7 - h[2:0]] ^ r.start_level; // RULE24
			end else if (~h[0]) begin
				next_r.level = ~r.level; // RULE24
			end else begin
				next_r.level = r.level ^ word[h[5:1]]; // RULE1 RULE24
			end
		end
		// serial side data latched on strobe edges, first half on rising
		if (st_rise) begin
			next_r.u_a = r.pin[`AES_PIN_USER]; // RULE15
			next_r.v_a = r.pin[`AES_PIN_FLAW];
			next_r.c_a = r.pin[`AES_PIN_CSER]; // RULE14
		end
		if (st_fall) begin
			next_r.u_b = r.pin[`AES_PIN_USER];
			next_r.v_b = r.pin[`AES_PIN_FLAW];
			next_r.c_b = r.pin[`AES_PIN_CSER];
		end
		// block start output pulse, one strobe period long at frame 0
		if (~dir_eff | soft_hold) begin
			next_r.bs_out = 1'h0;
		end else if (bs_edge) begin
			next_r.bs_out = (r.frame == 9'h0); // RULE6 RULE7
		end
		next_r.bs_oe = dir_eff; // RULE3
		// line driver pair
		case (src_sel)
			aes_pkg::SRC_ENC: begin
				next_r.line_p = r.level;
				next_r.line_n = ~r.level;
			end
			aes_pkg::SRC_EXT: begin
				next_r.line_p = r.pin[`AES_PIN_EXT];
				next_r.line_n = ~r.pin[`AES_PIN_EXT];
			end
			default: begin
				next_r.line_p = 1'h0;
				next_r.line_n = 1'h0;
			end
		endcase
		next_r.hresp = 1'h0;
	end

	// state register
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			r           <= '0;
			r.ctrl      <= `AES_CTRL_RST;
			r.hreadyout <= 1'h1;
		end else begin
			r <= next_r;
		end
	end

	// outputs straight from the state register
	assign HRDATA               = r.hrdata;
	assign HREADYOUT            = r.hreadyout;
	assign HRESP                = r.hresp;
	assign BLOCK_START_LINE_OUT = r.bs_out;
	assign BLOCK_START_LINE_OE  = r.bs_oe;
	assign LINE_OUT_P           = r.line_p;
	assign LINE_OUT_N           = r.line_n;

	default clocking dc @(posedge CLOCK);
	endclocking
	default disable iff (RST);

	// line guarding, source and block start checks
	mute_reset_a: assert property (soft_hold |=> !LINE_OUT_P && !LINE_OUT_N) // RULE20
		else $error("line not grounded in soft reset or power-down");
	off_ground_a: assert property (!hw_mode && r.ctrl[`AES_CTRL_OFF] // RULE21
		|=> !LINE_OUT_P && !LINE_OUT_N)
		else $error("line not grounded while disabled");
	arm_wait_a: assert property (!r.armed ##1 !r.armed |-> !LINE_OUT_P && !LINE_OUT_N) // RULE22
		else $error("line active before first rising strobe");
	pair_comp_a: assert property (!muted |=> LINE_OUT_P != LINE_OUT_N) // RULE24
		else $error("line pair not complementary");
	bypass_src_a: assert property (!muted && !hw_mode && r.ctrl[`AES_CTRL_BYPASS]
		|=> LINE_OUT_P == $past(r.pin[`AES_PIN_EXT])) // RULE18
		else $error("bypass does not follow external stream");
	hw_encoder_a: assert property (!muted && hw_mode |=> LINE_OUT_P == $past(r.level)) // RULE19
		else $error("hardware mode line not fed by encoder");
	dir_follow_a: assert property (dir_eff ##1 dir_eff |-> BLOCK_START_LINE_OE) // RULE3
		else $error("block start not driven in output direction");
	bs_rise_a: assert property ($rose(BLOCK_START_LINE_OUT) // RULE6
		|-> $past(bs_edge) && $past(r.frame) == 9'h0)
		else $error("block start rose away from frame 0");
	bs_input_a: assert property (bs_hit && !soft_hold |=> r.frame == 9'h0) // RULE4
		else $error("sampled block start did not restart the block");
	bs_fall_a: assert property (BLOCK_START_LINE_OUT && bs_edge && r.frame != 9'h0 // RULE6
		|=> !BLOCK_START_LINE_OUT)
		else $error("block start did not fall on next edge");

endmodule : aes_side_core

`default_nettype wire

// ### tb/aes_src_model.sv
// frame strobe and serial side data source that feeds the core
`timescale 1ns/1ps
`default_nettype none
module aes_src_model #(
	parameter int HALF = 64
) (
	input  wire logic clock,  // core clock
	input  wire logic run,    // strobe runs while high
	input  wire logic bs_req, // ask for a block start
	output var  logic strobe, // frame rate strobe
	output var  logic bs_in,  // block start level seen by the core
	output var  logic ser     // serial side data bit
);
	int cnt;
	initial begin
		cnt = 0;
		strobe = 1'b0;
		bs_in = 1'b0;
		ser = 1'b0;
	end
	// one strobe period is one frame; the strobe stands still when stopped
	always @(posedge clock) begin
		if (run) begin
			cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
			if (cnt == HALF - 1) begin
				strobe <= ~strobe;
				ser <= ~ser;
			end
		end
	end
	// block start stands high across the rising strobe edge only
	always @(posedge clock) begin
		bs_in <= bs_req & (strobe ? (cnt < HALF / 2) : (cnt >= HALF / 2));
	end
endmodule : aes_src_model
`default_nettype wire

// ### tb/tb_aes3_side_data_and_block_start.sv
// self-checking bench of the side data core
`timescale 1ns/1ps
`default_nettype none
`include "aes_defs.svh"
module tb_aes3_side_data_and_block_start;
	logic        CLOCK, RST, HSEL, HWRITE, HREADYOUT, HRESP, LINE_OUT_P, LINE_OUT_N;
	logic        run, bs_req, ext, strobe, bs_in, ser, bs_out, bs_oe;
	logic [1:0]  HTRANS;
	logic [5:0]  hw;
	logic [23:0] aud;
	logic [31:0] HADDR, HWDATA, HRDATA, q;
	int          num_errors, checks_done, n, e;
	localparam logic [40:0] ROWS [10] = '{
		{1'b1, 8'h00, 32'h0000_019B}, {1'b0, 8'h00, 32'h0000_019B},
		{1'b1, 8'h00, 32'h0000_0000}, {1'b0, 8'h00, 32'h0000_0000},
		{1'b1, 8'h40, 32'hA5A5_5A5A}, {1'b0, 8'h40, 32'hA5A5_5A5A},
		{1'b1, 8'h6C, 32'h8000_0001}, {1'b0, 8'h6C, 32'h8000_0001},
		{1'b1, 8'h80, 32'hFFFF_FFFF}, {1'b0, 8'h80, 32'h0000_0000}
	};
	aes_side_core i_dut (
		.CLOCK(CLOCK), .RST(RST), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
		.HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA), .HREADY(HREADYOUT),
		.HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .AUDIO_LEFT(aud),
		.AUDIO_RIGHT(~aud), .FRAME_STROBE(strobe), .HW_MODE(hw[0]),
		.BLOCK_START_DIR_SELECT(hw[1]), .FORMAT_SEL(hw[3:2]),
		.STATUS_INPUT_METHOD_SELECT(hw[4]), .COPY_PIN(hw[5]), .GENERATION_PIN(hw[5]),
		.NON_PCM_N(1'b1), .FILTER_CURVE_FLAG_N(1'b1), .STATUS_SERIAL(ser),
		.USER_SERIAL(ser), .SAMPLE_FLAWED_SERIAL(ser), .EXTERNAL_BIPHASE_IN(ext),
		.BLOCK_START_LINE_IN(bs_in), .BLOCK_START_LINE_OUT(bs_out),
		.BLOCK_START_LINE_OE(bs_oe), .LINE_OUT_P(LINE_OUT_P), .LINE_OUT_N(LINE_OUT_N)
	);
	aes_src_model #(.HALF(64)) i_src (
		.clock(CLOCK), .run(run), .bs_req(bs_req), .strobe(strobe), .bs_in(bs_in),
		.ser(ser)
	);
	// 250 MHz core clock
	initial begin
		CLOCK = 1'b0;
		forever #2 CLOCK = ~CLOCK;
	end
	task automatic test_done;
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : test_done
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD %s exp %h got %h", nm, exp, got);
		end
	endtask : chk
	// wait for ready high at an edge, bounded
	task automatic rdy;
		int k;
		k = 0;
		@(posedge CLOCK);
		while (HREADYOUT !== 1'b1 && k < 50) begin
			k++;
			@(posedge CLOCK);
		end
		if (HREADYOUT !== 1'b1) begin
			num_errors++;
			test_done();
		end
	endtask : rdy
	// one single word transfer, entered just after a rising edge
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
			output logic [31:0] r);
		HSEL <= 1'b1;
		HTRANS <= 2'h2;
		HWRITE <= w;
		HADDR <= {24'h0, a};
		rdy();
		HSEL <= 1'b0;
		HTRANS <= 2'h0;
		HWDATA <= d;
		rdy();
		r = HRDATA;
	endtask : bus
	// cycles until the block start output reaches a level, bounded
	task automatic wait_bs(input logic lvl, output int c);
		c = 0;
		do begin
			@(posedge CLOCK);
			c++;
		end while (bs_out !== lvl && c < 30000);
		if (bs_out !== lvl) begin
			num_errors++;
			test_done();
		end
	endtask : wait_bs
	// line toggles and equal-level cycles over one frame
	task automatic tog(output int t, output int s);
		logic p;
		t = 0;
		s = 0;
		p = LINE_OUT_P;
		repeat (128) begin
			@(posedge CLOCK);
			t += int'(LINE_OUT_P !== p);
			s += int'(LINE_OUT_P === LINE_OUT_N);
			p = LINE_OUT_P;
		end
	endtask : tog
	// register rows, then line source, reset and block start cases
	initial begin
		RST = 1'b1;
		{HSEL, HWRITE, run, bs_req, ext} = 5'h00;
		HTRANS = 2'h0;
		HADDR = 32'h0;
		HWDATA = 32'h0;
		hw = 6'h00;
		aud = 24'h5AC381;
		num_errors = 0;
		checks_done = 0;
		repeat (10) @(posedge CLOCK);
		RST <= 1'b0;
		run <= 1'b1;
		@(posedge CLOCK);
		foreach (ROWS[i]) begin
			bus(ROWS[i][40], ROWS[i][39:32], ROWS[i][31:0], q);
			if (!ROWS[i][40])
				chk("reg", q, ROWS[i][31:0]);
		end
		repeat (300) @(posedge CLOCK);
		tog(n, e);
		chk("cells", 32'(n >= 60 && n <= 128), 32'h1);
		chk("pair", 32'(e), 32'h0);
		bus(1'b1, `AES_CTRL_OFS, 32'h80, q);
		repeat (10) @(posedge CLOCK);
		tog(n, e);
		chk("off", {LINE_OUT_P, LINE_OUT_N, n[29:0]}, 32'h0);
		bus(1'b1, `AES_CTRL_OFS, 32'h08, q);
		ext <= 1'b1;
		repeat (20) @(posedge CLOCK);
		chk("ext1", {30'h0, LINE_OUT_P, LINE_OUT_N}, 32'h2);
		ext <= 1'b0;
		repeat (20) @(posedge CLOCK);
		chk("ext0", {30'h0, LINE_OUT_P, LINE_OUT_N}, 32'h1);
		hw <= 6'h03;
		repeat (300) @(posedge CLOCK);
		tog(n, e);
		chk("hwenc", 32'(n >= 60), 32'h1);
		chk("hwdir", {31'h0, bs_oe}, 32'h1);
		hw <= 6'h00;
		RST <= 1'b1;
		run <= 1'b0;
		repeat (3) @(posedge CLOCK);
		chk("rst", {30'h0, LINE_OUT_P, LINE_OUT_N}, 32'h0);
		RST <= 1'b0;
		@(posedge CLOCK);
		bus(1'b0, `AES_CTRL_OFS, 32'h0, q);
		chk("ctrl", q, {21'h0, `AES_CTRL_RST});
		bus(1'b1, `AES_CTRL_OFS, 32'h0, q);
		repeat (300) @(posedge CLOCK);
		chk("arm", {30'h0, LINE_OUT_P, LINE_OUT_N}, 32'h0);
		run <= 1'b1;
		repeat (300) @(posedge CLOCK);
		tog(n, e);
		chk("run", 32'(n >= 60), 32'h1);
		bus(1'b1, `AES_CTRL_OFS, 32'h01, q);
		wait_bs(1'b1, n);
		chk("ph0", {31'h0, strobe}, 32'h0);
		chk("oe", {31'h0, bs_oe}, 32'h1);
		wait_bs(1'b0, n);
		chk("high", 32'(n), 32'd128);
		wait_bs(1'b1, e);
		chk("block", 32'(n + e), 32'd24576);
		bus(1'b1, `AES_CTRL_OFS, 32'h101, q);
		wait_bs(1'b0, n);
		wait_bs(1'b1, n);
		chk("ph1", {31'h0, strobe}, 32'h1);
		bus(1'b1, `AES_CTRL_OFS, 32'h0, q);
		bs_req <= 1'b1;
		repeat (150) @(posedge CLOCK);
		bs_req <= 1'b0;
		bus(1'b0, `AES_STAT_OFS, 32'h0, q);
		chk("frame", 32'(q[8:0] < 9'h3), 32'h1);
		chk("resp", {31'h0, HRESP}, 32'h0);
		test_done();
	end
endmodule : tb_aes3_side_data_and_block_start
`default_nettype wire
